// ===== amgsr_map.svh
// Register map constants for the amplifier mute, gain and status register bank.
// Assumes the includer wants plain `define names; the file holds definitions only.
`ifndef AMGSR_MAP_SVH
`define AMGSR_MAP_SVH

// ----------------------------------------------------------------------------
// Pages and offsets
// ----------------------------------------------------------------------------
`define AMGSR_PAGE_STATUS 8'h00
`define AMGSR_PAGE_ANALOG 8'h01
`define AMGSR_AMP_TYPE_OFS 8'h01
`define AMGSR_GAIN_OFS 8'h02
`define AMGSR_FOLLOW_OFS 8'h06
`define AMGSR_BOOST_OFS 8'h07
`define AMGSR_MUTE_MON_OFS 8'h6c
`define AMGSR_PIN_LVL_OFS 8'h77
`define AMGSR_AUTO_MUTE_OFS 8'h78

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AMGSR_LEFT_MUTE_BIT 1
`define AMGSR_RIGHT_MUTE_BIT 0
`define AMGSR_SER_OUT_BIT 5
`define AMGSR_MUTE_PIN_BIT 4
`define AMGSR_LEFT_AUTO_BIT 4
`define AMGSR_RIGHT_AUTO_BIT 0
`define AMGSR_AMP_TYPE_BIT 0
`define AMGSR_LEFT_GAIN_BIT 4
`define AMGSR_RIGHT_GAIN_BIT 0
`define AMGSR_FOLLOW_BIT 0
`define AMGSR_LEFT_BOOST_BIT 4
`define AMGSR_RIGHT_BOOST_BIT 0

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define AMGSR_AMP_TYPE_RST 8'h00
`define AMGSR_GAIN_RST 8'h00
`define AMGSR_FOLLOW_RST 8'h01
`define AMGSR_BOOST_RST 8'h00
`define AMGSR_RSV_RST 8'h00
`define AMGSR_FULL_WMASK 8'hff
`define AMGSR_MON_WMASK 8'hfc
`define AMGSR_PIN_WMASK 8'hc0
`define AMGSR_AUTO_WMASK 8'hee

`endif

// ===== amgsr_pkg.sv
// Types shared by the register bank modules.
// Assumes nothing beyond a SystemVerilog compiler.
package amgsr_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef logic [7:0] amgsr_byte_t;

  // Synchronised status levels seen by the register bank.
  typedef struct packed {
    logic left_analog_mute_state;
    logic right_analog_mute_state;
    logic serial_out_pin_level;
    logic mute_pin_level;
    logic left_auto_mute_flag;
    logic right_auto_mute_flag;
  } amgsr_sts_t;

endpackage : amgsr_pkg

// ===== amgsr_sts_if.sv
// Carrier for synchronised status levels between the synchroniser and the bank.
// Assumes one clock domain on the receiving side.
`timescale 1ns/100ps

interface amgsr_sts_if;

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  amgsr_pkg::amgsr_sts_t sts;

  // The synchroniser drives, the register bank reads.
  modport src (output sts);
  modport dst (input sts);

endinterface : amgsr_sts_if

// ===== amgsr_sync.sv
// Two-stage synchroniser for the pin and analog status levels.
// Assumes every input is asynchronous to i_sys_clk and changes slowly.
`timescale 1ns/100ps

module amgsr_sync (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Raw levels.
  input wire amgsr_pkg::amgsr_sts_t i_raw,
  // Synchronised levels.
  amgsr_sts_if.src sync_out
);

  amgsr_pkg::amgsr_sts_t stage1;
  amgsr_pkg::amgsr_sts_t stage2;

  // The first stage feeds only the second; all levels read zero in reset.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= i_raw;
      stage2 <= stage1;
    end
  end

  assign sync_out.sts = stage2;

endmodule : amgsr_sync

// ===== amgsr_ctl_reg.sv
// One byte-wide register with a reset value and a mask of writable bits.
// Assumes the write strobe is a one-cycle pulse on i_sys_clk.
`timescale 1ns/100ps

module amgsr_ctl_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Write port.
  input wire logic i_wr,
  input wire amgsr_pkg::amgsr_byte_t i_data,
  // Stored value.
  output amgsr_pkg::amgsr_byte_t o_q
);

  // Bits outside the mask stay zero, so read-only positions never hold data.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= RST_VAL;
    end else if (i_wr) begin
      o_q <= i_data & WR_MASK;
    end
  end

endmodule : amgsr_ctl_reg

// ===== amgsr_top.sv
// Control and status register bank for a stereo digital-input amplifier.
// Assumes the control bus decoder outside presents page, offset, and one-cycle
// read and write strobes on i_sys_clk; status inputs are asynchronous levels.
`timescale 1ns/100ps
`include "amgsr_map.svh"

module amgsr_top (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register access port.
  input wire amgsr_pkg::amgsr_byte_t i_page,
  input wire amgsr_pkg::amgsr_byte_t i_addr,
  input wire logic i_wr_en,
  input wire amgsr_pkg::amgsr_byte_t i_wr_data,
  input wire logic i_rd_en,
  output amgsr_pkg::amgsr_byte_t o_rd_data,
  output logic o_rd_valid,
  // Monitored levels, asynchronous.
  input wire logic i_left_analog_mute_state,
  input wire logic i_right_analog_mute_state,
  input wire logic i_serial_data_out_pin,
  input wire logic i_mute_pin,
  input wire logic i_left_auto_mute_flag,
  input wire logic i_right_auto_mute_flag,
  // Clock logic state, same clock.
  input wire logic i_pll_enable,
  // Controls to the analog and clock logic.
  output logic o_amplitude_type_select,
  output logic o_left_gain_step,
  output logic o_right_gain_step,
  output logic o_analog_mute_follow_enable,
  output logic o_left_amplitude_boost,
  output logic o_right_amplitude_boost,
  output logic o_clock_autoset_blocked
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------

  // Matches one page and offset; used for every register.
  function automatic logic amgsr_hit(input logic [7:0] pg, input logic [7:0] ofs,
                                     input logic [7:0] want_pg, input logic [7:0] want_ofs);
    amgsr_hit = (pg == want_pg) && (ofs == want_ofs);
  endfunction : amgsr_hit

  // Places one status level at its bit position in an otherwise zero byte.
  function automatic logic [7:0] amgsr_at(input logic lvl, input int pos);
    amgsr_at = 8'(lvl) << pos;
  endfunction : amgsr_at

  wire logic sel_amp_type;
  wire logic sel_gain;
  wire logic sel_follow;
  wire logic sel_boost;
  wire logic sel_mute_mon;
  wire logic sel_pin_lvl;
  wire logic sel_auto_mute;

  assign sel_amp_type = amgsr_hit(i_page, i_addr, `AMGSR_PAGE_ANALOG, `AMGSR_AMP_TYPE_OFS);
  assign sel_gain = amgsr_hit(i_page, i_addr, `AMGSR_PAGE_ANALOG, `AMGSR_GAIN_OFS);
  assign sel_follow = amgsr_hit(i_page, i_addr, `AMGSR_PAGE_ANALOG, `AMGSR_FOLLOW_OFS);
  assign sel_boost = amgsr_hit(i_page, i_addr, `AMGSR_PAGE_ANALOG, `AMGSR_BOOST_OFS);
  assign sel_mute_mon = amgsr_hit(i_page, i_addr, `AMGSR_PAGE_STATUS, `AMGSR_MUTE_MON_OFS);
  assign sel_pin_lvl = amgsr_hit(i_page, i_addr, `AMGSR_PAGE_STATUS, `AMGSR_PIN_LVL_OFS);
  assign sel_auto_mute = amgsr_hit(i_page, i_addr, `AMGSR_PAGE_STATUS, `AMGSR_AUTO_MUTE_OFS);

  // --------------------------------------------------------------------------
  // Status synchronisation
  // --------------------------------------------------------------------------

  amgsr_sts_if sts_if ();
  amgsr_pkg::amgsr_sts_t raw_sts;

  // Pins and analog monitors are outside this clock, so each passes two flops.
  assign raw_sts = '{left_analog_mute_state: i_left_analog_mute_state,
                     right_analog_mute_state: i_right_analog_mute_state,
                     serial_out_pin_level: i_serial_data_out_pin,
                     mute_pin_level: i_mute_pin,
                     left_auto_mute_flag: i_left_auto_mute_flag,
                     right_auto_mute_flag: i_right_auto_mute_flag};

  amgsr_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_raw(raw_sts),
    .sync_out(sts_if.src)
  );

  // --------------------------------------------------------------------------
  // Writable registers
  // --------------------------------------------------------------------------

  amgsr_pkg::amgsr_byte_t amp_type_q;
  amgsr_pkg::amgsr_byte_t gain_q;
  amgsr_pkg::amgsr_byte_t follow_q;
  amgsr_pkg::amgsr_byte_t boost_q;
  amgsr_pkg::amgsr_byte_t mon_rsv_q;
  amgsr_pkg::amgsr_byte_t pin_rsv_q;
  amgsr_pkg::amgsr_byte_t auto_rsv_q;

  // Amplitude type register; reserved bits are stored and read back.
  amgsr_ctl_reg #(.RST_VAL(`AMGSR_AMP_TYPE_RST), .WR_MASK(`AMGSR_FULL_WMASK)) u_amp_type (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(i_wr_en && sel_amp_type),
    .i_data(i_wr_data),
    .o_q(amp_type_q)
  );

  // Gain step register for both channels.
  amgsr_ctl_reg #(.RST_VAL(`AMGSR_GAIN_RST), .WR_MASK(`AMGSR_FULL_WMASK)) u_gain (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(i_wr_en && sel_gain),
    .i_data(i_wr_data),
    .o_q(gain_q)
  );

  // Mute follow register comes out of reset with the coupling on.
  amgsr_ctl_reg #(.RST_VAL(`AMGSR_FOLLOW_RST), .WR_MASK(`AMGSR_FULL_WMASK)) u_follow (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(i_wr_en && sel_follow),
    .i_data(i_wr_data),
    .o_q(follow_q)
  );

  // Amplitude boost register for both channels.
  amgsr_ctl_reg #(.RST_VAL(`AMGSR_BOOST_RST), .WR_MASK(`AMGSR_FULL_WMASK)) u_boost (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(i_wr_en && sel_boost),
    .i_data(i_wr_data),
    .o_q(boost_q)
  );

  // Status registers keep only their writable reserved bits; the masks drop
  // any host write aimed at a status position.
  amgsr_ctl_reg #(.RST_VAL(`AMGSR_RSV_RST), .WR_MASK(`AMGSR_MON_WMASK)) u_mon_rsv (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(i_wr_en && sel_mute_mon),
    .i_data(i_wr_data),
    .o_q(mon_rsv_q)
  );

  amgsr_ctl_reg #(.RST_VAL(`AMGSR_RSV_RST), .WR_MASK(`AMGSR_PIN_WMASK)) u_pin_rsv (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(i_wr_en && sel_pin_lvl),
    .i_data(i_wr_data),
    .o_q(pin_rsv_q)
  );

  amgsr_ctl_reg #(.RST_VAL(`AMGSR_RSV_RST), .WR_MASK(`AMGSR_AUTO_WMASK)) u_auto_rsv (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(i_wr_en && sel_auto_mute),
    .i_data(i_wr_data),
    .o_q(auto_rsv_q)
  );

  // --------------------------------------------------------------------------
  // Control outputs
  // --------------------------------------------------------------------------

  // Each control comes straight from its stored bit.
  assign o_amplitude_type_select = amp_type_q[`AMGSR_AMP_TYPE_BIT];
  assign o_left_gain_step = gain_q[`AMGSR_LEFT_GAIN_BIT];
  assign o_right_gain_step = gain_q[`AMGSR_RIGHT_GAIN_BIT];
  assign o_analog_mute_follow_enable = follow_q[`AMGSR_FOLLOW_BIT];
  assign o_left_amplitude_boost = boost_q[`AMGSR_LEFT_BOOST_BIT];
  assign o_right_amplitude_boost = boost_q[`AMGSR_RIGHT_BOOST_BIT];

  // Clock logic must not auto-configure with the PLL on in supply-tracking
  // mode; registered so the clock logic sees a glitch-free level.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clock_autoset_blocked <= 1'b0;
    end else begin
      o_clock_autoset_blocked <= i_pll_enable && o_amplitude_type_select;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------

  wire amgsr_pkg::amgsr_byte_t mon_word;
  wire amgsr_pkg::amgsr_byte_t pin_word;
  wire amgsr_pkg::amgsr_byte_t auto_word;
  amgsr_pkg::amgsr_byte_t next_rd_data;

  // Mute monitor: 0 means muted, so the level is passed as is.
  assign mon_word = mon_rsv_q
      | amgsr_at(sts_if.sts.left_analog_mute_state, `AMGSR_LEFT_MUTE_BIT)
      | amgsr_at(sts_if.sts.right_analog_mute_state, `AMGSR_RIGHT_MUTE_BIT);

  // Pin levels; the reserved low nibble is returned as zero so reads repeat.
  assign pin_word = pin_rsv_q
      | amgsr_at(sts_if.sts.serial_out_pin_level, `AMGSR_SER_OUT_BIT)
      | amgsr_at(sts_if.sts.mute_pin_level, `AMGSR_MUTE_PIN_BIT);

  // Auto-mute flags follow the mute logic; nothing here latches them.
  assign auto_word = auto_rsv_q
      | amgsr_at(sts_if.sts.left_auto_mute_flag, `AMGSR_LEFT_AUTO_BIT)
      | amgsr_at(sts_if.sts.right_auto_mute_flag, `AMGSR_RIGHT_AUTO_BIT);

  // Unmapped offsets read as zero rather than aliasing another register.
  always_comb begin
    next_rd_data = 8'h00;
    unique case (1'b1)
      sel_amp_type: next_rd_data = amp_type_q;
      sel_gain: next_rd_data = gain_q;
      sel_follow: next_rd_data = follow_q;
      sel_boost: next_rd_data = boost_q;
      sel_mute_mon: next_rd_data = mon_word;
      sel_pin_lvl: next_rd_data = pin_word;
      sel_auto_mute: next_rd_data = auto_word;
      default: next_rd_data = 8'h00;
    endcase
  end

  // Read data is captured on the edge that samples the strobe and held until the next.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= next_rd_data;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Status reads return the synchronised level sampled at the strobe.
  left_mute_read_a: assert property (i_rd_en && sel_mute_mon |=>
      o_rd_valid && o_rd_data[1] == $past(sts_if.sts.left_analog_mute_state))
    else $error("Left analog mute bit does not match the monitor.");

  right_mute_read_a: assert property (i_rd_en && sel_mute_mon |=>
      o_rd_data[0] == $past(sts_if.sts.right_analog_mute_state))
    else $error("Right analog mute bit does not match the monitor.");

  // A pin level reaches the read data three edges after it settles.
  ser_out_read_a: assert property ($stable(i_serial_data_out_pin)[*3] ##0
      (i_rd_en && sel_pin_lvl) |=> o_rd_data[5] == $past(i_serial_data_out_pin))
    else $error("Serial data out pin level read back wrong.");

  mute_pin_read_a: assert property ($stable(i_mute_pin)[*3] ##0
      (i_rd_en && sel_pin_lvl) |=> o_rd_data[4] == $past(i_mute_pin))
    else $error("Mute pin level read back wrong.");

  pin_low_nibble_a: assert property (i_rd_en && sel_pin_lvl |=>
      o_rd_data[3:0] == 4'h0)
    else $error("Pin level register low nibble is not zero.");

  left_auto_read_a: assert property (i_rd_en && sel_auto_mute |=>
      o_rd_data[4] == $past(sts_if.sts.left_auto_mute_flag))
    else $error("Left auto-mute flag read back wrong.");

  right_auto_read_a: assert property (i_rd_en && sel_auto_mute |=>
      o_rd_data[0] == $past(sts_if.sts.right_auto_mute_flag))
    else $error("Right auto-mute flag read back wrong.");

  amp_type_write_a: assert property (i_wr_en && sel_amp_type |=>
      o_amplitude_type_select == $past(i_wr_data[0]))
    else $error("Amplitude type select did not take the written bit.");

  autoset_block_a: assert property (i_pll_enable && o_amplitude_type_select |=>
      o_clock_autoset_blocked ##1 (o_clock_autoset_blocked == $past(i_pll_enable
      && o_amplitude_type_select)))
    else $error("Clock autoset block does not follow PLL and amplitude mode.");

  left_gain_write_a: assert property (i_wr_en && sel_gain |=>
      o_left_gain_step == $past(i_wr_data[4]))
    else $error("Left gain step did not take the written bit.");

  right_gain_write_a: assert property (i_wr_en && sel_gain |=>
      o_right_gain_step == $past(i_wr_data[0]))
    else $error("Right gain step did not take the written bit.");

  follow_hold_a: assert property (!(i_wr_en && sel_follow) |=>
      $stable(o_analog_mute_follow_enable))
    else $error("Mute follow enable changed without a write.");

  left_boost_write_a: assert property (i_wr_en && sel_boost |=>
      o_left_amplitude_boost == $past(i_wr_data[4]))
    else $error("Left amplitude boost did not take the written bit.");

  right_boost_write_a: assert property (i_wr_en && sel_boost |=>
      o_right_amplitude_boost == $past(i_wr_data[0]))
    else $error("Right amplitude boost did not take the written bit.");

  status_ro_bits_a: assert property (mon_rsv_q[1:0] == 2'h0 && pin_rsv_q[5:0] == 6'h00
      && auto_rsv_q[4] == 1'b0 && auto_rsv_q[0] == 1'b0)
    else $error("A read-only status position stored a host write.");

  // Controls stand until their own register is written again.
  amp_type_hold_a: assert property (!(i_wr_en && sel_amp_type) |=>
      $stable(o_amplitude_type_select))
    else $error("Amplitude type select changed without a write.");

  gain_hold_a: assert property (!(i_wr_en && sel_gain) |=>
      $stable(o_left_gain_step) && $stable(o_right_gain_step))
    else $error("A gain step changed without a write.");

  follow_write_a: assert property (i_wr_en && sel_follow |=>
      o_analog_mute_follow_enable == $past(i_wr_data[0]))
    else $error("Mute follow enable did not take the written bit.");

  boost_hold_a: assert property (!(i_wr_en && sel_boost) |=>
      $stable(o_left_amplitude_boost) && $stable(o_right_amplitude_boost))
    else $error("An amplitude boost changed without a write.");

  // --------------------------------------------------------------------------
  // Cover properties
  // --------------------------------------------------------------------------

  supply_mode_pll_c: cover property (i_pll_enable && o_amplitude_type_select
      ##1 o_clock_autoset_blocked);

  follow_cleared_c: cover property (o_analog_mute_follow_enable
      ##1 !o_analog_mute_follow_enable);

  left_muted_read_c: cover property (i_rd_en && sel_mute_mon
      && !sts_if.sts.left_analog_mute_state ##1 o_rd_valid);

  auto_flag_read_c: cover property (i_rd_en && sel_auto_mute
      && sts_if.sts.right_auto_mute_flag ##1 o_rd_data[0]);

  status_write_drop_c: cover property (i_wr_en && sel_mute_mon && i_wr_data[1]
      ##1 !mon_rsv_q[1]);

endmodule : amgsr_top

// ===== amgsr_host_model.sv
// Host-side model that issues register writes and reads on the access port.
// Assumes one-cycle strobes on rising edges of i_sys_clk and a read answer one cycle later.
`timescale 1ns/100ps

module amgsr_host_model (
  // Clock.
  input wire logic i_sys_clk,
  // Answer from the register bank.
  input wire amgsr_pkg::amgsr_byte_t i_rd_data,
  input wire logic i_rd_valid,
  // Requests to the register bank.
  output amgsr_pkg::amgsr_byte_t o_page,
  output amgsr_pkg::amgsr_byte_t o_addr,
  output logic o_wr_en,
  output amgsr_pkg::amgsr_byte_t o_wr_data,
  output logic o_rd_en
);
  // --------------------------------------------------------------------------
  // Idle request lines
  // --------------------------------------------------------------------------
  // Everything starts idle so no strobe is seen during reset.
  initial begin
    o_page = 8'h00;
    o_addr = 8'h00;
    o_wr_en = 1'b0;
    o_wr_data = 8'h00;
    o_rd_en = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  // One write; callers keep reserved bits at zero in mapped registers.
  task automatic wr_reg(input logic [7:0] pg, input logic [7:0] ofs, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_page <= pg;
    o_addr <= ofs;
    o_wr_data <= d;
    o_wr_en <= 1'b1;
    @(posedge i_sys_clk);
    o_wr_en <= 1'b0;
  endtask : wr_reg

  // One read; the answer is taken at mid-cycle so it is settled, within a bound.
  task automatic rd_reg(input logic [7:0] pg, input logic [7:0] ofs,
                        output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_sys_clk);
    o_page <= pg;
    o_addr <= ofs;
    o_rd_en <= 1'b1;
    @(posedge i_sys_clk);
    o_rd_en <= 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge i_sys_clk);
      if (i_rd_valid === 1'b1) begin
        d = i_rd_data;
        ok = 1'b1;
      end
    end
  endtask : rd_reg
endmodule : amgsr_host_model

// ===== tb_top.sv
// Self-checking bench for the amplifier mute, gain and status register bank.
// Assumes the host model drives the access port and the bench drives the status levels.
`timescale 1ns/100ps

module tb_top;
  // Compares one value and counts the outcome.
  `define AMGSR_CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic pll_on = 1'b0;
  amgsr_pkg::amgsr_sts_t raw = '0;
  amgsr_pkg::amgsr_byte_t page, addr, wr_data, rd_data;
  logic wr_en, rd_en, rd_valid, autoset_blocked;
  wire logic [5:0] ctl;
  int fail_count = 0;
  int check_count = 0;
  logic [7:0] rsv_ofs [4] = '{8'h01, 8'h02, 8'h06, 8'h07};
  logic [7:0] rsv_val [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] w_ofs [6] = '{8'h01, 8'h02, 8'h02, 8'h06, 8'h07, 8'h07};
  logic [7:0] w_dat [6] = '{8'h01, 8'h10, 8'h01, 8'h00, 8'h10, 8'h01};
  logic [5:0] w_ctl [6] = '{6'h24, 6'h34, 6'h2c, 6'h28, 6'h2a, 6'h29};

  // The clock inverts every half period of 20 ns.
  always #20 i_sys_clk = ~i_sys_clk;

  // --------------------------------------------------------------------------
  // Design and host
  // --------------------------------------------------------------------------
  amgsr_top dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_page(page), .i_addr(addr),
    .i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .i_left_analog_mute_state(raw.left_analog_mute_state),
    .i_right_analog_mute_state(raw.right_analog_mute_state),
    .i_serial_data_out_pin(raw.serial_out_pin_level), .i_mute_pin(raw.mute_pin_level),
    .i_left_auto_mute_flag(raw.left_auto_mute_flag),
    .i_right_auto_mute_flag(raw.right_auto_mute_flag), .i_pll_enable(pll_on),
    .o_amplitude_type_select(ctl[5]), .o_left_gain_step(ctl[4]), .o_right_gain_step(ctl[3]),
    .o_analog_mute_follow_enable(ctl[2]), .o_left_amplitude_boost(ctl[1]),
    .o_right_amplitude_boost(ctl[0]), .o_clock_autoset_blocked(autoset_blocked));

  amgsr_host_model host (.i_sys_clk(i_sys_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_page(page), .o_addr(addr), .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Reads one register and compares the bits under the mask; a lost answer ends the run.
  task automatic rd_chk(input logic [7:0] pg, input logic [7:0] ofs,
                        input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd_reg(pg, ofs, d, ok);
    if (!ok) begin
      fail_count++;
      tally_and_finish();
    end else begin
      `AMGSR_CHK(d & mask, exp)
    end
  endtask : rd_chk

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  // Reset, register defaults, control writes, live status, refusals, then the verdict.
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(negedge i_sys_clk);
    `AMGSR_CHK({ctl, autoset_blocked}, 7'h08)
    for (int i = 0; i < 4; i++) rd_chk(8'h01, rsv_ofs[i], 8'hff, rsv_val[i]);
    rd_chk(8'h00, 8'h77, 8'hf0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      host.wr_reg(8'h01, w_ofs[i], w_dat[i]);
      @(negedge i_sys_clk);
      `AMGSR_CHK(ctl, w_ctl[i])
      rd_chk(8'h01, w_ofs[i], 8'hff, w_dat[i]);
    end
    // Supply-tracking mode alone must not block autoset while the PLL is off.
    `AMGSR_CHK(autoset_blocked, 1'b0)
    // Supply-tracking mode is on now, so enabling the PLL must block autoset.
    @(posedge i_sys_clk);
    pll_on <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    `AMGSR_CHK(autoset_blocked, 1'b1)
    host.wr_reg(8'h01, 8'h01, 8'h00);
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    `AMGSR_CHK(autoset_blocked, 1'b0)
    // Two opposite status patterns so every field is seen at both levels.
    for (int p = 0; p < 2; p++) begin
      @(posedge i_sys_clk);
      raw <= (p == 0) ? 6'b101010 : 6'b010101;
      repeat (4) @(posedge i_sys_clk);
      rd_chk(8'h00, 8'h6c, 8'hff, (p == 0) ? 8'h02 : 8'h01);
      rd_chk(8'h00, 8'h77, 8'hf0, (p == 0) ? 8'h20 : 8'h10);
      rd_chk(8'h00, 8'h78, 8'hff, (p == 0) ? 8'h10 : 8'h01);
    end
    // Writes to read-only status bits and to unmapped places must leave no trace.
    host.wr_reg(8'h00, 8'h6c, 8'h02);
    host.wr_reg(8'h00, 8'h78, 8'h10);
    rd_chk(8'h00, 8'h6c, 8'hff, 8'h01);
    rd_chk(8'h00, 8'h78, 8'hff, 8'h01);
    host.wr_reg(8'h01, 8'h03, 8'hff);
    rd_chk(8'h01, 8'h03, 8'hff, 8'h00);
    rd_chk(8'h00, 8'h01, 8'hff, 8'h00);
    @(negedge i_sys_clk);
    `AMGSR_CHK(ctl, 6'h09)
    tally_and_finish();
  end
endmodule : tb_top
